// ---- mbio_cfg.svh ----
// address map, field positions, codes and timing constants for the modbus i/o block
// assumes a single 25 MHz clock and a protocol layer that hands over one item per request
// What this block does
// - allocated input bits are read bit by bit with function 2 from direct address 0 (legacy 10001).
// - allocated input words are read with function 3 from direct 1024 (legacy 46001) in allocation order.
// - slot input bits sit at 1024 + 8*slot + bit - 1 (legacy 13001) and are read with function 2.
// - the module status high byte is read bit by bit at 2048 + 8*slot + bit - 1 (legacy 14001).
// - function 4 returns the status word at 768 + slot (legacy 35200) and the type word at legacy 35300.
// - allocated output bits at direct 0 (legacy 1) are written by functions 5 and 15 and read by 1.
// - allocated output words at 1280 (legacy 46101) are written by functions 6 and 16, read by 3.
// - slot output coils at 1024 + 8*slot + bit - 1 (legacy 3001) are written by 5 and 15, read by 1.
// - each output line reports lead breakage or short circuit in its own line fault bit.
// - line fault detection can be switched off, and then no line fault is reported.
// - after three failed exchanges in a row the outputs switch off once 500 ms have passed.
// - input byte bit 2(n-1) is channel n output state, bit 2(n-1)+1 its line fault (1 = error).
// - output byte bit 2(n-1) is channel n value; bit 2(n-1)+1 set applies the substitute value.
`ifndef MBIO_CFG_SVH
`define MBIO_CFG_SVH

// direct address bases
`define MBIO_ALLOC_DI_BASE    16'h0000
`define MBIO_ALLOC_COIL_BASE  16'h0000
`define MBIO_STATUS_WORD_BASE 16'h0300
`define MBIO_ALLOC_HRIN_BASE  16'h0400
`define MBIO_SLOT_DI_BASE     16'h0400
`define MBIO_TYPE_WORD_BASE   16'h0400
`define MBIO_SLOT_COIL_BASE   16'h0400
`define MBIO_ALLOC_HROUT_BASE 16'h0500
`define MBIO_STATUS_HI_BASE   16'h0800
// legacy one-based equivalents
`define MBIO_LEG_ALLOC_DI     10001
`define MBIO_LEG_ALLOC_HRIN   46001
`define MBIO_LEG_SLOT_DI      13001
`define MBIO_LEG_STATUS_HI    14001
`define MBIO_LEG_STATUS_WORD  35200
`define MBIO_LEG_TYPE_WORD    35300
`define MBIO_LEG_ALLOC_COIL   1
`define MBIO_LEG_ALLOC_HROUT  46101
`define MBIO_LEG_SLOT_COIL    3001
// bits per slot in slot-based bit areas
`define MBIO_BITS_PER_SLOT    16'h0008
// allocated items that this module holds
`define MBIO_ALLOC_BITS       16'h0008
`define MBIO_ALLOC_WORDS      16'h0001
// own slot on the backplane and its type word (type value arbitrary)
`define MBIO_OWN_SLOT         16'h0001
`define MBIO_TYPE_WORD        16'h5A01
// function codes
`define MBIO_FC_RD_COILS      8'h01
`define MBIO_FC_RD_DI         8'h02
`define MBIO_FC_RD_HR         8'h03
`define MBIO_FC_RD_IR         8'h04
`define MBIO_FC_WR_COIL       8'h05
`define MBIO_FC_WR_REG        8'h06
`define MBIO_FC_WR_COILS      8'h0F
`define MBIO_FC_WR_REGS       8'h10
// exception codes
`define MBIO_EXC_NONE         8'h00
`define MBIO_EXC_ILL_FUNC     8'h01
`define MBIO_EXC_ILL_ADDR     8'h02
`define MBIO_EXC_ILL_VALUE    8'h03
// single coil write values
`define MBIO_COIL_ON          16'hFF00
`define MBIO_COIL_OFF         16'h0000
// status word field positions
`define MBIO_ST_LFD_OFF_BIT   8
`define MBIO_ST_WD_TRIP_BIT   9
`define MBIO_ST_ANY_FAULT_BIT 10
`define MBIO_ST_FAULT_LSB     12
// timing
`define MBIO_CLK_HZ           25000000
`define MBIO_TICK_TIME_MS     1
`define MBIO_TICK_CYCLES      ((`MBIO_CLK_HZ / 1000) * `MBIO_TICK_TIME_MS)
`define MBIO_WD_TIME_MS       500
`define MBIO_WD_TICKS         (`MBIO_WD_TIME_MS / `MBIO_TICK_TIME_MS)
`define MBIO_WD_FAIL_LIMIT    2'h3

`endif

// ---- mbio_pkg.sv ----
// shared types of the modbus i/o block
// assumes the constants header is compiled alongside
`default_nettype none
package mbio_pkg;
  typedef logic [15:0] mbio_word_t;
  typedef enum logic [1:0] {WD_RUN, WD_WAIT, WD_OFF} mbio_wd_state_t;
endpackage : mbio_pkg
`default_nettype wire

// ---- mbio_line_fault.sv ----
// per-channel line fault detection with pin synchronisers
// assumes open and short sense comparators arrive asynchronously on pins
`include "mbio_cfg.svh"
`default_nettype none
module mbio_line_fault (
  input  wire logic       mclk,       // 25 MHz clock
  input  wire logic       rst_b,      // sync reset, active low
  input  wire logic [3:0] openSense,  // lead breakage comparator pins
  input  wire logic [3:0] shortSense, // short circuit comparator pins
  input  wire logic       lfdOff,     // detection switched off
  output logic      [3:0] lineFault   // per-channel fault, 1 = error
);
  logic [3:0] openS1_ff, openS2_ff, openS3_ff, openOk_ff;
  logic [3:0] shrtS1_ff, shrtS2_ff, shrtS3_ff, shrtOk_ff;
  logic [3:0] lineFault_ff;

  // three-stage pin synchronisers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      openS1_ff <= 4'h0;
      openS2_ff <= 4'h0;
      openS3_ff <= 4'h0;
      shrtS1_ff <= 4'h0;
      shrtS2_ff <= 4'h0;
      shrtS3_ff <= 4'h0;
    end else begin
      openS1_ff <= openSense;
      openS2_ff <= openS1_ff;
      openS3_ff <= openS2_ff;
      shrtS1_ff <= shortSense;
      shrtS2_ff <= shrtS1_ff;
      shrtS3_ff <= shrtS2_ff;
    end
  end

  // accept a level once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      openOk_ff <= 4'h0;
      shrtOk_ff <= 4'h0;
    end else begin
      openOk_ff <= (openS2_ff & openS3_ff) | (openOk_ff & (openS2_ff | openS3_ff));
      shrtOk_ff <= (shrtS2_ff & shrtS3_ff) | (shrtOk_ff & (shrtS2_ff | shrtS3_ff));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lineFault_ff <= 4'h0;
    end else begin
      lineFault_ff <= lfdOff ? 4'h0 : (openOk_ff | shrtOk_ff);
    end
  end

  assign lineFault = lineFault_ff;
endmodule : mbio_line_fault
`default_nettype wire

// ---- mbio_watchdog.sv ----
// communication watchdog of the output module
// assumes one-cycle pulses marking each finished exchange with the com unit
`include "mbio_cfg.svh"
`default_nettype none
module mbio_watchdog #(
  parameter int unsigned TICK_CYCLES = `MBIO_TICK_CYCLES // cycles per millisecond tick
) (
  input  wire logic mclk,     // 25 MHz clock
  input  wire logic rst_b,    // sync reset, active low
  input  wire logic commOk,   // pulse: exchange succeeded
  input  wire logic commFail, // pulse: exchange failed
  output logic      wdTrip    // outputs forced off
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [9:0]  WD_LAST   = 10'(`MBIO_WD_TICKS - 1);

  mbio_pkg::mbio_wd_state_t state_ff;
  logic [1:0]  failCnt_ff;
  logic [15:0] divCnt_ff;
  logic        tick_ff;
  logic [9:0]  msCnt_ff;
  logic        wdTrip_ff;

  // millisecond enable divider, restarted on entry to the wait
  always_ff @(posedge mclk) begin
    if (!rst_b || state_ff != mbio_pkg::WD_WAIT) begin
      divCnt_ff <= 16'h0000;
      tick_ff   <= 1'b0;
    end else begin
      tick_ff   <= (divCnt_ff == TICK_LAST);
      divCnt_ff <= (divCnt_ff == TICK_LAST) ? 16'h0000 : divCnt_ff + 16'h0001;
    end
  end

  // consecutive failure count; a success clears it
  always_ff @(posedge mclk) begin
    if (!rst_b || commOk) begin
      failCnt_ff <= 2'h0;
    end else if (commFail && failCnt_ff != `MBIO_WD_FAIL_LIMIT) begin
      failCnt_ff <= failCnt_ff + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || commOk) begin
      state_ff  <= mbio_pkg::WD_RUN;
      msCnt_ff  <= 10'h000;
      wdTrip_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        mbio_pkg::WD_RUN: begin
          msCnt_ff <= 10'h000;
          if (commFail && failCnt_ff == `MBIO_WD_FAIL_LIMIT - 2'h1) begin
            state_ff <= mbio_pkg::WD_WAIT;
          end
        end
        mbio_pkg::WD_WAIT: begin
          if (tick_ff) begin
            msCnt_ff <= msCnt_ff + 10'h001;
            if (msCnt_ff == WD_LAST) begin
              state_ff  <= mbio_pkg::WD_OFF;
              wdTrip_ff <= 1'b1;
            end
          end
        end
        mbio_pkg::WD_OFF: begin
          wdTrip_ff <= 1'b1;
        end
        default: begin
          state_ff <= mbio_pkg::WD_RUN;
        end
      endcase
    end
  end

  assign wdTrip = wdTrip_ff;
endmodule : mbio_watchdog
`default_nettype wire

// ---- mbio_top.sv ----
// modbus address decode and process image of a four-channel digital output module
// assumes the protocol layer splits multi-item functions into one item per request
`include "mbio_cfg.svh"
`default_nettype none
module mbio_top #(
  parameter int unsigned TICK_CYCLES = `MBIO_TICK_CYCLES // cycles per millisecond tick
) (
  input  wire logic        mclk,       // 25 MHz clock
  input  wire logic        rst_b,      // sync reset, active low
  input  wire logic        reqValid,   // one-cycle request strobe
  input  wire logic [7:0]  reqFunc,    // modbus function code
  input  wire logic [15:0] reqAddr,    // direct item address
  input  wire logic [15:0] reqWrData,  // write item value
  output logic             respValid,  // one-cycle answer strobe
  output logic [15:0]      respData,   // read value, bit items in bit 0
  output logic [7:0]       respExc,    // exception code, 0 when none
  input  wire logic        commOk,     // pulse: exchange with com unit ok
  input  wire logic        commFail,   // pulse: exchange with com unit failed
  input  wire logic        lfdOff,     // line fault detection off
  input  wire logic [3:0]  substVal,   // substitute value per channel
  input  wire logic [3:0]  openSense,  // lead breakage sense pins
  input  wire logic [3:0]  shortSense, // short circuit sense pins
  output logic      [3:0]  chanOut,    // output channel drive
  output logic      [3:0]  lineFault,  // per-channel line fault
  output logic             wdTrip      // watchdog has switched off
);
  logic [7:0]  outByte_ff;   // output byte: value/invalid pairs
  logic [3:0]  chanOut_ff;
  logic        respValid_ff;
  logic [15:0] respData_ff;
  logic [7:0]  respExc_ff;
  logic [7:0]  nxt_outByte;
  logic [15:0] nxt_respData;
  logic [7:0]  nxt_respExc;
  logic [7:0]  inByte;
  logic [15:0] statusWord;
  logic [3:0]  faultBits;
  logic        wdTripInt;

  // finds whether an address falls into this slot's eight bits
  function automatic logic [3:0] slotBitHit(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] first;
    logic [15:0] rel;
    first = base + 16'(`MBIO_BITS_PER_SLOT * `MBIO_OWN_SLOT);
    rel   = addr - first;
    slotBitHit = {(addr >= first) && (rel < `MBIO_BITS_PER_SLOT), rel[2:0]};
  endfunction : slotBitHit

  // finds an allocated item of a given count
  function automatic logic inRange(input logic [15:0] addr, input logic [15:0] base,
                                   input logic [15:0] count);
    inRange = (addr >= base) && ((addr - base) < count);
  endfunction : inRange

  mbio_line_fault uLineFault (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .openSense  (openSense),
    .shortSense (shortSense),
    .lfdOff     (lfdOff),
    .lineFault  (faultBits)
  );

  mbio_watchdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) uWatchdog (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .commOk   (commOk),
    .commFail (commFail),
    .wdTrip   (wdTripInt)
  );

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      inByte[2*n]   = chanOut_ff[n];
      inByte[2*n+1] = faultBits[n];
    end
  end

  // module status word; high byte served bit by bit too
  always_comb begin
    statusWord = 16'h0000;
    statusWord[`MBIO_ST_LFD_OFF_BIT]   = lfdOff;
    statusWord[`MBIO_ST_WD_TRIP_BIT]   = wdTripInt;
    statusWord[`MBIO_ST_ANY_FAULT_BIT] = |faultBits;
    statusWord[`MBIO_ST_FAULT_LSB +: 4] = faultBits;
  end

  // address decode and answer
  always_comb begin
    logic [3:0] sDi;
    logic [3:0] sHi;
    logic [3:0] sCo;
    logic       aCo;
    logic       aDi;
    logic       aHin;
    logic       aHout;
    logic       bitVal;
    sDi   = slotBitHit(reqAddr, `MBIO_SLOT_DI_BASE);
    sHi   = slotBitHit(reqAddr, `MBIO_STATUS_HI_BASE);
    sCo   = slotBitHit(reqAddr, `MBIO_SLOT_COIL_BASE);
    aCo   = inRange(reqAddr, `MBIO_ALLOC_COIL_BASE, `MBIO_ALLOC_BITS);
    aDi   = inRange(reqAddr, `MBIO_ALLOC_DI_BASE, `MBIO_ALLOC_BITS);
    aHin  = inRange(reqAddr, `MBIO_ALLOC_HRIN_BASE, `MBIO_ALLOC_WORDS);
    aHout = inRange(reqAddr, `MBIO_ALLOC_HROUT_BASE, `MBIO_ALLOC_WORDS);
    bitVal = 1'b0;
    nxt_outByte  = outByte_ff;
    nxt_respData = 16'h0000;
    nxt_respExc  = `MBIO_EXC_NONE;
    unique case (reqFunc)
      `MBIO_FC_RD_COILS: begin
        if (aCo) begin
          nxt_respData = {15'h0000, outByte_ff[reqAddr[2:0]]};
        end else if (sCo[3]) begin
          nxt_respData = {15'h0000, outByte_ff[sCo[2:0]]};
        end else begin
          nxt_respExc = `MBIO_EXC_ILL_ADDR;
        end
      end
      `MBIO_FC_RD_DI: begin
        if (aDi) begin
          nxt_respData = {15'h0000, inByte[reqAddr[2:0]]};
        end else if (sDi[3]) begin
          nxt_respData = {15'h0000, inByte[sDi[2:0]]};
        end else if (sHi[3]) begin
          nxt_respData = {15'h0000, statusWord[{1'b1, sHi[2:0]}]};
        end else begin
          nxt_respExc = `MBIO_EXC_ILL_ADDR;
        end
      end
      `MBIO_FC_RD_HR: begin
        if (aHin) begin
          nxt_respData = {8'h00, inByte};
        end else if (aHout) begin
          nxt_respData = {8'h00, outByte_ff};
        end else begin
          nxt_respExc = `MBIO_EXC_ILL_ADDR;
        end
      end
      `MBIO_FC_RD_IR: begin
        if (reqAddr == `MBIO_STATUS_WORD_BASE + `MBIO_OWN_SLOT) begin
          nxt_respData = statusWord;
        end else if (reqAddr == `MBIO_TYPE_WORD_BASE + `MBIO_OWN_SLOT) begin
          nxt_respData = `MBIO_TYPE_WORD;
        end else begin
          nxt_respExc = `MBIO_EXC_ILL_ADDR;
        end
      end
      `MBIO_FC_WR_COIL, `MBIO_FC_WR_COILS: begin
        // single coil takes only the two legal values
        if (reqFunc == `MBIO_FC_WR_COIL && reqWrData != `MBIO_COIL_ON
            && reqWrData != `MBIO_COIL_OFF) begin
          nxt_respExc = `MBIO_EXC_ILL_VALUE;
        end else begin
          bitVal = (reqFunc == `MBIO_FC_WR_COIL) ? reqWrData[15] : reqWrData[0];
          if (aCo) begin
            nxt_outByte[reqAddr[2:0]] = bitVal;
          end else if (sCo[3]) begin
            nxt_outByte[sCo[2:0]] = bitVal;
          end else begin
            nxt_respExc = `MBIO_EXC_ILL_ADDR;
          end
        end
        nxt_respData = reqWrData;
      end
      `MBIO_FC_WR_REG, `MBIO_FC_WR_REGS: begin
        if (aHout) begin
          nxt_outByte = reqWrData[7:0];
        end else begin
          nxt_respExc = `MBIO_EXC_ILL_ADDR;
        end
        nxt_respData = reqWrData;
      end
      default: begin
        nxt_respExc = `MBIO_EXC_ILL_FUNC;
      end
    endcase
    if (nxt_respExc != `MBIO_EXC_NONE) begin
      nxt_respData = 16'h0000;
      nxt_outByte  = outByte_ff;
    end
  end

  // output byte updated by accepted writes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      outByte_ff <= 8'h00;
    end else if (reqValid) begin
      outByte_ff <= nxt_outByte;
    end
  end

  // answer registers, one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      respValid_ff <= 1'b0;
      respData_ff  <= 16'h0000;
      respExc_ff   <= 8'h00;
    end else begin
      respValid_ff <= reqValid;
      if (reqValid) begin
        respData_ff <= nxt_respData;
        respExc_ff  <= nxt_respExc;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      chanOut_ff <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (wdTripInt) begin
          chanOut_ff[n] <= 1'b0;
        end else if (outByte_ff[2*n+1]) begin
          chanOut_ff[n] <= substVal[n];
        end else begin
          chanOut_ff[n] <= outByte_ff[2*n];
        end
      end
    end
  end

  assign respValid = respValid_ff;
  assign respData  = respData_ff;
  assign respExc   = respExc_ff;
  assign chanOut   = chanOut_ff;
  assign lineFault = faultBits;
  assign wdTrip    = wdTripInt;
endmodule : mbio_top
`default_nettype wire

// ---- mbio_top_asserts.sv ----
// concurrent checks on the ports of the modbus i/o block
// assumes one clock domain and the synchronous active-low reset
`include "mbio_cfg.svh"
`default_nettype none
module mbio_top_chk #(
  parameter int unsigned TICK_CYCLES = `MBIO_TICK_CYCLES // cycles per millisecond tick
) (
  input wire logic        mclk,       // clock
  input wire logic        rst_b,      // sync reset, active low
  input wire logic        reqValid,   // request strobe
  input wire logic [7:0]  reqFunc,    // function code
  input wire logic [15:0] reqAddr,    // item address
  input wire logic [15:0] reqWrData,  // write value
  input wire logic        respValid,  // answer strobe
  input wire logic [15:0] respData,   // answer value
  input wire logic [7:0]  respExc,    // answer exception
  input wire logic        commOk,     // exchange ok
  input wire logic        commFail,   // exchange failed
  input wire logic        lfdOff,     // detection off
  input wire logic [3:0]  substVal,   // substitute values
  input wire logic [3:0]  openSense,  // breakage pins
  input wire logic [3:0]  shortSense, // short pins
  input wire logic [3:0]  chanOut,    // channel drive
  input wire logic [3:0]  lineFault,  // line faults
  input wire logic        wdTrip      // watchdog trip
);
  localparam logic [15:0] TYPE_ADDR = `MBIO_TYPE_WORD_BASE + `MBIO_OWN_SLOT;
  localparam logic [15:0] STHI_ADDR = `MBIO_STATUS_HI_BASE + 16'h0008 * `MBIO_OWN_SLOT;
  logic isFunc; // supported function code
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // decode of supported functions
  assign isFunc = reqFunc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};
  a_resp_after_req: assert property (reqValid |=> respValid)
    else $error("request not answered one cycle later");
  a_resp_no_req: assert property (!reqValid |=> !respValid)
    else $error("answer without a request");
  a_bad_func_exc: assert property (reqValid && !isFunc |=>
    respExc == `MBIO_EXC_ILL_FUNC && respData == 16'h0000)
    else $error("unsupported function not refused");
  a_type_word_read: assert property (reqValid && reqFunc == `MBIO_FC_RD_IR &&
    reqAddr == TYPE_ADDR |=> respData == `MBIO_TYPE_WORD && respExc == 8'h00)
    else $error("type word read wrong");
  a_alloc_di_state: assert property (reqValid && reqFunc == `MBIO_FC_RD_DI &&
    reqAddr == 16'h0000 |=> respData[0] == $past(chanOut[0]) && respExc == 8'h00)
    else $error("first input bit not the channel state");
  a_status_lfd_bit: assert property (reqValid && reqFunc == `MBIO_FC_RD_DI &&
    reqAddr == STHI_ADDR |=> respData[0] == $past(lfdOff))
    else $error("status high byte bit 0 wrong");
  a_write_word_echo: assert property (reqValid && reqFunc == `MBIO_FC_WR_REG &&
    reqAddr == `MBIO_ALLOC_HROUT_BASE |=> respData == $past(reqWrData) && respExc == 8'h00)
    else $error("output word write not accepted");
  a_trip_outs_off: assert property (wdTrip |=> chanOut == 4'h0)
    else $error("outputs drive while tripped");
  a_ok_releases: assert property (commOk |=> !wdTrip)
    else $error("good exchange did not release trip");
  a_lfd_off_mask: assert property (lfdOff [*2] |-> lineFault == 4'h0)
    else $error("line fault reported while detection off");
  // main scenarios reached
  c_coil_write: cover property (reqValid && reqFunc == `MBIO_FC_WR_COIL);
  c_wd_trip: cover property ($rose(wdTrip));
  c_bad_addr: cover property (reqValid ##1 respExc == `MBIO_EXC_ILL_ADDR);
endmodule : mbio_top_chk
`default_nettype wire

// ---- mbio_master_model.sv ----
// modbus master model issuing one item per request
// assumes the block answers with a one-cycle strobe
`default_nettype none
module mbio_master_model (
  input  wire logic        mclk,      // bench clock
  input  wire logic        respValid, // answer strobe
  input  wire logic [15:0] respData,  // answer value
  input  wire logic [7:0]  respExc,   // answer exception
  output var logic         reqValid,  // request strobe
  output var logic  [7:0]  reqFunc,   // function code
  output var logic  [15:0] reqAddr,   // item address
  output var logic  [15:0] reqWrData  // write value
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle request lines at time zero
  initial begin
    reqValid  = 1'b0;
    reqFunc   = 8'hA5;
    reqAddr   = 16'hA5A5;
    reqWrData = 16'h5A5A;
  end
  // one item per request, any function code passed through as given
  task automatic request(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                         input int gap, output logic [15:0] rdat, output logic [7:0] rexc);
    rdat = 16'hXXXX;
    rexc = 8'hXX;
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    reqValid  <= 1'b1;
    reqFunc   <= f;
    reqAddr   <= a;
    reqWrData <= d;
    @(posedge mclk);
    // released lines show the inverse of the last value
    reqValid  <= 1'b0;
    reqFunc   <= ~f;
    reqAddr   <= ~a;
    reqWrData <= ~d;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      if (respValid === 1'b1) begin
        rdat = respData;
        rexc = respExc;
        break;
      end
    end
  endtask : request
endmodule : mbio_master_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the modbus i/o address map
// assumes the master model drives every request pin
`include "mbio_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SC = 16'h0400 + 16'h0008 * `MBIO_OWN_SLOT; // slot bit base
  localparam logic [15:0] SH = 16'h0800 + 16'h0008 * `MBIO_OWN_SLOT; // status bit base
  logic        mclk       = 1'b0;
  logic        rst_b      = 1'b0;
  logic        commOk     = 1'b0;
  logic        commFail   = 1'b0;
  logic        lfdOff     = 1'b0;
  logic [3:0]  substVal   = 4'h0;
  logic [3:0]  openSense  = 4'h0;
  logic [3:0]  shortSense = 4'h0;
  logic        reqValid, respValid, wdTrip, v, trip;
  logic [7:0]  reqFunc, respExc, ex, outByte;
  logic [15:0] reqAddr, reqWrData, respData, rd;
  logic [3:0]  chanOut, lineFault, lfModel;
  int          miscompares = 0;
  int          tests_run   = 0;
  // clock of 40 ns
  always #20 mclk = ~mclk;
  mbio_top #(.TICK_CYCLES(4)) u_dut (.mclk(mclk), .rst_b(rst_b), .reqValid(reqValid),
    .reqFunc(reqFunc), .reqAddr(reqAddr), .reqWrData(reqWrData), .respValid(respValid),
    .respData(respData), .respExc(respExc), .commOk(commOk), .commFail(commFail),
    .lfdOff(lfdOff), .substVal(substVal), .openSense(openSense), .shortSense(shortSense),
    .chanOut(chanOut), .lineFault(lineFault), .wdTrip(wdTrip));
  mbio_master_model u_mst (.mclk(mclk), .respValid(respValid), .respData(respData),
    .respExc(respExc), .reqValid(reqValid), .reqFunc(reqFunc), .reqAddr(reqAddr),
    .reqWrData(reqWrData));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // one request with a random idle gap before it
  task automatic xact(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    u_mst.request(f, a, d, $urandom_range(0, 2), rd, ex);
  endtask : xact
  task automatic pulse(input logic ok);
    @(posedge mclk);
    if (ok) commOk <= 1'b1;
    else commFail <= 1'b1;
    @(posedge mclk);
    commOk   <= 1'b0;
    commFail <= 1'b0;
  endtask : pulse
  function automatic logic [3:0] chanExp();
    for (int n = 0; n < 4; n++)
      chanExp[n] = trip ? 1'b0 : (outByte[2*n+1] ? substVal[n] : outByte[2*n]);
  endfunction : chanExp
  function automatic logic [7:0] inb();
    logic [3:0] c;
    c = chanExp();
    for (int n = 0; n < 4; n++)
      inb[2*n +: 2] = {lfModel[n], c[n]};
  endfunction : inb
  function automatic logic [15:0] stat();
    stat = {lfModel, 1'b0, |lfModel, trip, lfdOff, 8'h00};
  endfunction : stat
  // main sequence
  initial begin
    outByte = 8'h00;
    lfModel = 4'h0;
    trip    = 1'b0;
    void'($urandom(32'h96CD1C3F));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    // coil writes, single and multiple, both areas
    for (int b = 0; b < 8; b++) begin
      v = 1'($urandom_range(0, 1));
      outByte[b] = v;
      if (b[1]) xact(`MBIO_FC_WR_COILS, (b[0] ? SC : 16'h0000) + 16'(b), {15'h0000, v});
      else xact(`MBIO_FC_WR_COIL, (b[0] ? SC : 16'h0000) + 16'(b), v ? 16'hFF00 : 16'h0000);
      check({8'h00, ex}, 16'h0000);
    end
    // bit reads of coils and input byte
    for (int b = 0; b < 8; b++) begin
      xact(`MBIO_FC_RD_COILS, 16'(b), 16'h0000);
      check(rd, {15'h0000, outByte[b]});
      xact(`MBIO_FC_RD_COILS, SC + 16'(b), 16'h0000);
      check(rd, {15'h0000, outByte[b]});
      xact(`MBIO_FC_RD_DI, 16'(b), 16'h0000);
      check(rd, 16'(inb() >> b) & 16'h0001);
      xact(`MBIO_FC_RD_DI, SC + 16'(b), 16'h0000);
      check(rd, 16'(inb() >> b) & 16'h0001);
    end
    // output word, substitute values and drive
    for (int k = 0; k < 2; k++) begin
      outByte  = 8'($urandom);
      substVal <= 4'($urandom);
      xact(k ? `MBIO_FC_WR_REGS : `MBIO_FC_WR_REG, 16'h0500, {8'h00, outByte});
      xact(`MBIO_FC_RD_HR, 16'h0500, 16'h0000);
      check(rd, {8'h00, outByte});
      @(posedge mclk);
      check({12'h000, chanOut}, {12'h000, chanExp()});
      xact(`MBIO_FC_RD_HR, 16'h0400, 16'h0000);
      check(rd, {8'h00, inb()});
    end
    // line faults with detection on and off
    openSense  <= 4'b0010;
    shortSense <= 4'b0100;
    for (int k = 0; k < 2; k++) begin
      lfdOff  <= k[0];
      lfModel = k ? 4'h0 : 4'b0110;
      repeat (8) @(posedge mclk);
      check({12'h000, lineFault}, {12'h000, lfModel});
      xact(`MBIO_FC_RD_IR, 16'h0300 + `MBIO_OWN_SLOT, 16'h0000);
      check(rd, stat());
      for (int b = 0; b < 8; b++) begin
        xact(`MBIO_FC_RD_DI, SH + 16'(b), 16'h0000);
        check(rd, (stat() >> (8 + b)) & 16'h0001);
      end
    end
    xact(`MBIO_FC_RD_IR, 16'h0400 + `MBIO_OWN_SLOT, 16'h0000);
    check(rd, `MBIO_TYPE_WORD);
    // refusals leave the output word unchanged
    xact(8'h07, 16'h0000, 16'h0000);
    check({8'h00, ex}, 16'h0001);
    xact(`MBIO_FC_RD_HR, 16'h07D0, 16'h0000);
    check({8'h00, ex}, 16'h0002);
    xact(`MBIO_FC_WR_REG, 16'h0400, 16'h0055);
    check({8'h00, ex}, 16'h0002);
    xact(`MBIO_FC_WR_COIL, 16'h0000, 16'h1234);
    check({8'h00, ex}, 16'h0003);
    xact(`MBIO_FC_RD_COILS, 16'h0008, 16'h0000);
    check(rd, 16'h0000);
    check({8'h00, ex}, 16'h0002);
    xact(`MBIO_FC_RD_HR, 16'h0500, 16'h0000);
    check(rd, {8'h00, outByte});
    // broken run of failures does not trip, three failures in a row do
    pulse(1'b0);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    repeat (2100) @(posedge mclk);
    check({15'h0000, wdTrip}, 16'h0000);
    pulse(1'b0);
    pulse(1'b0);
    repeat (1900) @(posedge mclk);
    check({15'h0000, wdTrip}, 16'h0000);
    for (int i = 0; i < 300 && wdTrip !== 1'b1; i++) @(posedge mclk);
    trip = 1'b1;
    @(posedge mclk);
    check({15'h0000, wdTrip}, 16'h0001);
    check({12'h000, chanOut}, {12'h000, chanExp()});
    pulse(1'b1);
    trip = 1'b0;
    @(posedge mclk);
    check({15'h0000, wdTrip}, 16'h0000);
    // drive follows the released trip one edge later
    @(posedge mclk);
    check({12'h000, chanOut}, {12'h000, chanExp()});
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
bind mbio_top mbio_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .reqValid(reqValid), .reqFunc(reqFunc), .reqAddr(reqAddr), .reqWrData(reqWrData),
  .respValid(respValid), .respData(respData), .respExc(respExc), .commOk(commOk),
  .commFail(commFail), .lfdOff(lfdOff), .substVal(substVal), .openSense(openSense),
  .shortSense(shortSense), .chanOut(chanOut), .lineFault(lineFault), .wdTrip(wdTrip));
`default_nettype wire
